/* logic/qdl_defs.svh */
// Named constants of the quad DAC serial loader.
// Assumes inclusion by bare name from the package and the loader module.
`ifndef QDL_DEFS_SVH
`define QDL_DEFS_SVH

// ****************************************
// Frame layout and counts
// ****************************************
`define QDL_FRAME_BITS 16
`define QDL_FRAME_MSB 15
`define QDL_NEXT_MSB 14
`define QDL_CNT_W 5
`define QDL_CNT_FULL 5'h10
`define QDL_CNT_ZERO 5'h00

// ****************************************
// Command codes (command_bits) and special-command channel codes (load all, falling edge, rising edge)
// ****************************************
`define QDL_CMD_INPUT 2'h0
`define QDL_CMD_INPUT_DAC 2'h1
`define QDL_CMD_SPECIAL 2'h2
`define QDL_SEL_ALL 2'h0
`define QDL_SEL_EDGE_FALL 2'h1
`define QDL_SEL_EDGE_RISE 2'h2

// ****************************************
// Reset and idle values
// ****************************************
`define QDL_SR_RST 16'h0000
`define QDL_CODE_RST 12'h000
`define QDL_ECHO_IDLE 1'b1
`define QDL_EDGE_RST 1'b0
`define QDL_FLAG_RST 1'b0
// Strobe high, select high, shift clock low, data low: matches the idle pins
`define QDL_PINS_IDLE 4'hc

`endif

/* logic/qdl_loader.sv */
// Serial loader of a four-channel, 12-bit DAC: shift register, frame buffer,
// double-buffered channel registers and serial echo.
// Assumes all pins are asynchronous to clk and sampled by it; shift clock well below clk/8.
//
// Summary of operation
// (R1) Shift serial_in on shift clock rise
// (R2) Shift and echo only while select low
// (R3) Select rise applies frame to registers
// (R4) Strobe low copies all input to DAC
// (R5) Echo output shows shift register far end
// (R6) Echo held high while deselected
// (R7) Falling-edge launch mode for echo
// (R8) Rising-edge launch mode for echo
// (R9) Sixteen bits, MSB first, full frame
// (R10) Per channel input and DAC registers
// (R11) Strobe held low gives transparent DAC
// (R12) Command table; undefined codes do nothing
`timescale 1ns/1ps
`include "qdl_defs.svh"

module qdl_loader #(
    parameter int NUM_CH = 4,
    parameter int CODE_W = 12,
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic load_all_strobe_n,
    output logic serial_echo_out,
    // Frame buffer drain and status
    input wire logic apply_ready,
    output logic frame_ready,
    output logic frame_overrun,
    output logic edge_rise_mode,
    // Converter codes
    output logic [NUM_CH-1:0][CODE_W-1:0] dac_code
);
    import qdl_pkg::*;

    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    qdl_pins_t pins_raw;
    qdl_pins_t s1_q, s2_q, s3_q;
    qdl_pins_t s1_d, s2_d, s3_d;

    assign pins_raw = '{load_all_strobe_n: load_all_strobe_n, cs_n: cs_n, sclk: sclk, serial_in: serial_in};

    // Stage one feeds stage two only; edges come from stages two and three
    always_comb begin
        s1_d = pins_raw;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_q <= qdl_pins_t'(`QDL_PINS_IDLE);
            s2_q <= qdl_pins_t'(`QDL_PINS_IDLE);
            s3_q <= qdl_pins_t'(`QDL_PINS_IDLE);
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    logic sck_rise, sck_fall, cs_rise, cs_fall, cs_low, strobe_low;
    assign sck_rise = s2_q.sclk & ~s3_q.sclk;
    assign sck_fall = ~s2_q.sclk & s3_q.sclk;
    assign cs_rise = s2_q.cs_n & ~s3_q.cs_n;
    assign cs_fall = ~s2_q.cs_n & s3_q.cs_n;
    assign cs_low = ~s2_q.cs_n;
    assign strobe_low = ~s2_q.load_all_strobe_n;

    // ****************************************
    // Shift register and serial echo
    // ****************************************
    logic [`QDL_FRAME_MSB:0] sr_q, sr_d;
    logic [`QDL_CNT_W-1:0] cnt_q, cnt_d;
    logic echo_q, echo_d;
    logic edge_q, edge_d;
    logic push, buf_full;
    logic overrun_q, overrun_d;

    // Shifting, launch edge and frame hand-off
    always_comb begin
        sr_d = sr_q;
        cnt_d = cnt_q;
        echo_d = echo_q;
        push = 1'b0;
        overrun_d = 1'b0;
        if (!cs_low) begin
            // (R6) Echo idles high
            echo_d = `QDL_ECHO_IDLE;
            // (R9) Only full frames count; a short frame is dropped
            if (cs_rise && cnt_q == `QDL_CNT_FULL) begin
                // (R3) Frame latched on select rise; overrun if buffer full
                push = ~buf_full;
                overrun_d = buf_full;
            end
        end else begin
            if (cs_fall) begin
                cnt_d = `QDL_CNT_ZERO;
                // (R5) First echoed bit is the far end
                echo_d = sr_q[`QDL_FRAME_MSB];
            end
            // (R1) Shift on rising shift clock, gated by (R2) select low
            if (sck_rise) begin
                sr_d = {sr_q[`QDL_NEXT_MSB:0], s2_q.serial_in};
                if (cnt_q != `QDL_CNT_FULL) begin
                    cnt_d = cnt_q + 1'b1;
                end
                // (R8) Rising-edge launch of the next bit
                if (edge_q) begin
                    echo_d = sr_q[`QDL_NEXT_MSB];
                end
            end
            // (R7) Falling-edge launch of the far-end bit
            if (sck_fall && !edge_q) begin
                echo_d = sr_q[`QDL_FRAME_MSB];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sr_q <= `QDL_SR_RST;
            cnt_q <= `QDL_CNT_ZERO;
            echo_q <= `QDL_ECHO_IDLE;
            overrun_q <= `QDL_FLAG_RST;
        end else begin
            sr_q <= sr_d;
            cnt_q <= cnt_d;
            echo_q <= echo_d;
            overrun_q <= overrun_d;
        end
    end

    assign serial_echo_out = echo_q;
    assign frame_overrun = overrun_q;

    // ****************************************
    // Two-entry frame buffer
    // ****************************************
    // Decouples frame capture from a stalled apply side, so a second frame still lands
    qdl_frame_t mem_q [BUF_DEPTH];
    qdl_frame_t mem_d [BUF_DEPTH];
    logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PTR_W:0] fill_q, fill_d;
    logic buf_valid, pop;

    assign buf_full = (fill_q == (PTR_W + 1)'(BUF_DEPTH));
    assign buf_valid = (fill_q != '0);
    assign pop = buf_valid & apply_ready;
    assign frame_ready = ~buf_full;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        fill_d = fill_q;
        if (push) begin
            mem_d[wr_q] = qdl_frame_t'(sr_q);
            wr_d = (wr_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        fill_d = fill_q + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            fill_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            fill_q <= fill_d;
        end
    end

    // ****************************************
    // Command decode
    // ****************************************
    qdl_frame_t head;
    qdl_act_t act;
    assign head = mem_q[rd_q];

    // (R12) Decode table; unlisted codes map to no action
    always_comb begin
        act = QDL_ACT_NONE;
        if (pop) begin
            case (head.command_bits)
                `QDL_CMD_INPUT: act = QDL_ACT_INPUT;
                `QDL_CMD_INPUT_DAC: act = QDL_ACT_INPUT_DAC;
                `QDL_CMD_SPECIAL: begin
                    case (head.channel_select_bits)
                        `QDL_SEL_ALL: act = QDL_ACT_ALL;
                        `QDL_SEL_EDGE_FALL: act = QDL_ACT_EDGE_FALL;
                        `QDL_SEL_EDGE_RISE: act = QDL_ACT_EDGE_RISE;
                        default: act = QDL_ACT_NONE;
                    endcase
                end
                default: act = QDL_ACT_NONE;
            endcase
        end
    end

    // Launch-edge mode register
    always_comb begin
        edge_d = edge_q;
        if (act == QDL_ACT_EDGE_RISE) begin
            edge_d = 1'b1;
        end else if (act == QDL_ACT_EDGE_FALL) begin
            edge_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            edge_q <= `QDL_EDGE_RST;
        end else begin
            edge_q <= edge_d;
        end
    end

    assign edge_rise_mode = edge_q;

    // ****************************************
    // Channel registers
    // ****************************************
    // (R10) Double buffer per channel
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        logic [CODE_W-1:0] in_q, in_d, dac_q, dac_d;
        logic hit;
        assign hit = (head.channel_select_bits == 2'(ch));

        always_comb begin
            in_d = in_q;
            dac_d = dac_q;
            if (hit && (act == QDL_ACT_INPUT || act == QDL_ACT_INPUT_DAC)) begin
                in_d = CODE_W'(head.code_bits);
            end
            if (hit && act == QDL_ACT_INPUT_DAC) begin
                dac_d = CODE_W'(head.code_bits);
            end
            if (act == QDL_ACT_ALL) begin
                dac_d = in_q;
            end
            // (R4) Strobe low copies input; held low it is (R11) transparent
            if (strobe_low) begin
                dac_d = in_d;
            end
        end

        always_ff @(posedge clk) begin
            if (!rstn) begin
                in_q <= CODE_W'(`QDL_CODE_RST);
                dac_q <= CODE_W'(`QDL_CODE_RST);
            end else begin
                in_q <= in_d;
                dac_q <= dac_d;
            end
        end

        assign dac_code[ch] = dac_q;
    end
endmodule : qdl_loader

/* logic/qdl_pkg.sv */
// Types shared by the quad DAC serial loader.
// Assumes qdl_defs.svh is on the include path.
`include "qdl_defs.svh"

package qdl_pkg;
    // One received frame, most significant field first
    typedef struct packed {
        logic [1:0] channel_select_bits;
        logic [1:0] command_bits;
        logic [11:0] code_bits;
    } qdl_frame_t;

    // Action decoded from a frame
    typedef enum logic [2:0] {
        QDL_ACT_NONE,
        QDL_ACT_INPUT,
        QDL_ACT_INPUT_DAC,
        QDL_ACT_ALL,
        QDL_ACT_EDGE_FALL,
        QDL_ACT_EDGE_RISE
    } qdl_act_t;

    // Synchronised pin levels
    typedef struct packed {
        logic load_all_strobe_n;
        logic cs_n;
        logic sclk;
        logic serial_in;
    } qdl_pins_t;
endpackage : qdl_pkg

/* tb/qdl_host.sv */
// Host serial master model driving the loader's select, shift clock and data.
// Assumes clk is the loader's clock; tasks are called just after a rising edge.
`timescale 1ns/1ps

module qdl_host (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic cs_n,
    output logic sclk,
    output logic serial_in,
    input wire logic serial_echo_out
);
    logic [15:0] echo_q;

    // Idle pins: select high, shift clock parked low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
    end

    // first nbits of the word, MSB first
    // Launch on fall, echo sampled just before each rise; 16 clks a phase gives 80 ns
    task automatic send(input logic [15:0] word, input int nbits);
        cs_n <= 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            serial_in <= word[i];
            repeat (16) @(posedge clk);
            echo_q = {echo_q[14:0], serial_echo_out};
            sclk <= 1'b1;
            repeat (16) @(posedge clk);
            sclk <= 1'b0;
        end
        // Released data line shows the inverse so no stale bit passes
        serial_in <= ~serial_in;
        cs_n <= 1'b1;
        repeat (16) @(posedge clk);
    endtask : send

    // edges ignored while deselected
    // Free-running shift clock with select high and data held at one
    task automatic spin(input int n);
        for (int i = 0; i < n; i++) begin
            serial_in <= 1'b1;
            repeat (16) @(posedge clk);
            sclk <= 1'b1;
            repeat (16) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (16) @(posedge clk);
    endtask : spin
endmodule : qdl_host

/* tb/qdl_loader_chk.sv */
// Concurrent checks on the loader's ports.
// Assumes it is bound to qdl_loader; pins asynchronous, sampled by clk.
`timescale 1ns/1ps

module qdl_loader_chk #(
    parameter int NUM_CH = 4,
    parameter int CODE_W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic load_all_strobe_n,
    input wire logic serial_echo_out,
    // Buffer and status
    input wire logic apply_ready,
    input wire logic frame_ready,
    input wire logic frame_overrun,
    input wire logic edge_rise_mode,
    // Converter codes
    input wire logic [NUM_CH-1:0][CODE_W-1:0] dac_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Five samples cover the select synchroniser latency
    a_echo_idle_high: assert property (cs_n [*5] |-> serial_echo_out)
        else $error("echo not high while deselected");
    a_dac_change_cause: assert property ($changed(dac_code) |-> $past(apply_ready)
        || !$past(load_all_strobe_n, 2) || !$past(load_all_strobe_n, 3) || !$past(load_all_strobe_n, 4))
        else $error("dac code changed without pop or strobe");
    a_mode_change_pop: assert property ($changed(edge_rise_mode) |-> $past(apply_ready))
        else $error("edge mode changed without pop");
    a_ready_fall_push: assert property ($fell(frame_ready) |-> cs_n)
        else $error("buffer filled while frame open");
    a_overrun_full: assert property (frame_overrun |-> !$past(frame_ready))
        else $error("overrun with room in buffer");
    a_overrun_pulse: assert property (frame_overrun |=> !frame_overrun)
        else $error("overrun longer than one cycle");
    // Echo moves 3 clks after its launch edge, so the shift clock level 2 back tells the edge
    a_echo_fall_edge: assert property ($changed(serial_echo_out) && !cs_n && !$past(cs_n, 4)
        && !edge_rise_mode |-> !$past(sclk, 2))
        else $error("echo moved off the falling edge");
    a_echo_rise_edge: assert property ($changed(serial_echo_out) && !cs_n && !$past(cs_n, 4)
        && edge_rise_mode |-> $past(sclk, 2))
        else $error("echo moved off the rising edge");
endmodule : qdl_loader_chk

/* tb/qdl_loader_test.sv */
// Self-checking bench of the loader with a host model and bound checker.
// Assumes a 200 MHz clk; strobe and apply_ready driven here.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t mismatch", $time); end end

module qdl_loader_test;
    import qdl_pkg::*;
    typedef struct packed {logic [15:0] word; logic [1:0] ch; logic [11:0] code; logic mode;} qdl_row_t;
    logic clk, rstn, load_all_strobe_n, apply_ready, serial_echo_out, cs_n, sclk, serial_in;
    logic frame_ready, frame_overrun, edge_rise_mode;
    logic [3:0][11:0] dac_code;
    logic [15:0] prev;
    int fails, samples_checked, ovr_cnt;
    // Word, channel watched, its code, echo mode
    qdl_row_t rows [9] = '{'{16'h1abc, 2'h0, 12'habc, 1'b0}, '{16'h5123, 2'h1, 12'h123, 1'b0},
        '{16'h8456, 2'h2, 12'h000, 1'b0}, '{16'h2000, 2'h2, 12'h456, 1'b0}, '{16'hf777, 2'h3, 12'h000, 1'b0},
        '{16'he000, 2'h3, 12'h000, 1'b0}, '{16'ha000, 2'h0, 12'habc, 1'b1}, '{16'hdfff, 2'h3, 12'hfff, 1'b1},
        '{16'h6000, 2'h1, 12'h123, 1'b0}};

    qdl_loader u_dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
        .load_all_strobe_n(load_all_strobe_n), .serial_echo_out(serial_echo_out), .apply_ready(apply_ready),
        .frame_ready(frame_ready), .frame_overrun(frame_overrun), .edge_rise_mode(edge_rise_mode),
        .dac_code(dac_code));
    qdl_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
        .serial_echo_out(serial_echo_out));

    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Overrun pulses are one cycle wide, so count them as they pass
    always @(posedge clk) begin
        if (frame_overrun === 1'b1) ovr_cnt++;
    end

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // Watchdog, about four times the expected run
    initial begin
        #200000;
        fails++;
        end_sim();
    end

    initial begin
        rstn = 1'b0;
        load_all_strobe_n = 1'b1;
        apply_ready = 1'b1;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(serial_echo_out, 1'b1)
        `CHK(dac_code, '0)
        `CHK({frame_ready, frame_overrun, edge_rise_mode}, 3'b100)
        repeat (4) @(posedge clk);
        prev = '0;
        foreach (rows[i]) begin
            u_host.send(rows[i].word, 16);
            `CHK(u_host.echo_q, prev)
            `CHK(dac_code[rows[i].ch], rows[i].code)
            `CHK(edge_rise_mode, rows[i].mode)
            prev = rows[i].word;
        end
        // Shift clock runs with select high: the shift register must not move
        u_host.spin(4);
        // Short frame must leave channel 0 alone
        u_host.send(16'h1000, 15);
        `CHK(dac_code[0], 12'habc)
        u_host.send(16'h0321, 16);
        `CHK(dac_code[0], 12'habc)
        // Echo is the last bit of 6000 then fifteen bits of the short frame
        `CHK(u_host.echo_q, 16'h0800)
        load_all_strobe_n <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(dac_code[0], 12'h321)
        u_host.send(16'h4999, 16);
        `CHK(dac_code[1], 12'h999)
        load_all_strobe_n <= 1'b1;
        // Stall the drain: two frames fill the buffer, the third is lost
        apply_ready <= 1'b0;
        u_host.send(16'h90aa, 16);
        u_host.send(16'hd0bb, 16);
        `CHK(frame_ready, 1'b0)
        u_host.send(16'h10cc, 16);
        `CHK(ovr_cnt, 1)
        apply_ready <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(dac_code, {12'h0bb, 12'h0aa, 12'h999, 12'h321})
        `CHK(frame_ready, 1'b1)
        // Mid-run reset after a mode change must restore every output
        u_host.send(16'ha000, 16);
        `CHK(edge_rise_mode, 1'b1)
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(dac_code, '0)
        `CHK({serial_echo_out, frame_ready, frame_overrun, edge_rise_mode}, 4'hc)
        repeat (4) @(posedge clk);
        // First frame after reset echoes the cleared shift register
        u_host.send(16'h1abc, 16);
        `CHK(u_host.echo_q, 16'h0000)
        `CHK(dac_code[0], 12'habc)
        end_sim();
    end
endmodule : qdl_loader_test

bind qdl_loader qdl_loader_chk #(.NUM_CH(NUM_CH), .CODE_W(CODE_W)) u_chk (.clk(clk), .rstn(rstn), .cs_n(cs_n),
    .sclk(sclk), .serial_in(serial_in), .load_all_strobe_n(load_all_strobe_n), .serial_echo_out(serial_echo_out),
    .apply_ready(apply_ready), .frame_ready(frame_ready), .frame_overrun(frame_overrun),
    .edge_rise_mode(edge_rise_mode), .dac_code(dac_code));
